/* cgen_map.svh */
// Purpose: offsets, field positions, reset values and counts of the clock
//          generator control block
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef CGEN_MAP_SVH
`define CGEN_MAP_SVH

// ****************************************
// register map
// ****************************************
`define CGEN_GATE_ADDR 16'hffe8
`define CGEN_GATE_BIT 0
`define CGEN_GATE_RST 1'b0
`define CGEN_RSV_WIDTH 15
`define CGEN_RSV_READ 15'h0000

// ****************************************
// timing counts
// ****************************************
`define CGEN_PLL_LOCK_CYC 2500
`define CGEN_PIN_SWITCH_CYC 2

`endif

/* cgen_pkg.sv */
// Purpose: types of the clock generator control block
// Assumes: nothing
// Notes:   mode encoding follows the strap pins, high pin first
package cgen_pkg;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      CGEN_MODE_STRAP_HI,
      CGEN_MUL1,
      CGEN_MUL2,
      CGEN_MUL4
   } cgen_mode_t;

   typedef enum logic [1:0] {
      CGEN_HOLD,
      CGEN_LOCK,
      CGEN_RUN
   } cgen_state_t;

endpackage : cgen_pkg

/* cgen_gate_if.sv */
// Purpose: master clock level and its running flag, passed to the pin gate
// Assumes: one clock domain
// Notes:   gen drives, gate listens
interface cgen_gate_if;
   logic master_q;
   logic running;

   modport gen (output master_q, output running);
   modport gate (input master_q, input running);
endinterface : cgen_gate_if

/* cgen_pin_gate.sv */
// Purpose: clock pin control register and gated master clock pin
// Assumes: io strobes are synchronous to core_clk, one cycle each
// Notes:   read data answer one cycle after the read strobe
`include "cgen_map.svh"

module cgen_pin_gate
   import cgen_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] io_addr,
   input wire logic [15:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   output logic [15:0] io_rdata,
   output logic master_clock_out,
   cgen_gate_if.gate gif
);

   // ****************************************
   // register and pin state
   // ****************************************
   logic gate_off_q;
   logic gate_off_d;
   logic pin_en_q;
   logic pin_en_d;
   logic pin_q;
   logic pin_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic hit;

   always_comb begin
      hit = (io_addr == `CGEN_GATE_ADDR);
      gate_off_d = gate_off_q;
      if (io_wr && hit) begin
         gate_off_d = io_wdata[`CGEN_GATE_BIT];
      end
      rdata_d = 16'h0000;
      if (io_rd && hit) begin
         rdata_d = {`CGEN_RSV_READ, gate_off_q};
      end
      pin_en_d = pin_en_q;
      if (!gif.master_q) begin
         pin_en_d = !gate_off_q;
      end
      pin_d = gif.master_q && pin_en_q;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         gate_off_q <= `CGEN_GATE_RST;
         pin_en_q <= 1'b1;
         pin_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         gate_off_q <= gate_off_d;
         pin_en_q <= pin_en_d;
         pin_q <= pin_d;
         rdata_q <= rdata_d;
      end
   end

   assign io_rdata = rdata_q;
   assign master_clock_out = pin_q;

   // ****************************************
   // checks
   // ****************************************
   gate_write_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (io_wr && io_addr == `CGEN_GATE_ADDR)
      |=> gate_off_q == $past(io_wdata[`CGEN_GATE_BIT]))
      else $error("gate bit did not take the written value");
   reserved_read_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (io_rd && io_addr == `CGEN_GATE_ADDR)
      |=> io_rdata == {15'h0000, $past(gate_off_q)})
      else $error("gate register read back wrong");
   reset_clear_a: assert property (
      @(posedge core_clk)
      rst |=> !gate_off_q && pin_en_q)
      else $error("reset did not enable the pin");
   pin_off_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (!pin_en_q) |=> !master_clock_out)
      else $error("pin toggles while gated off");
   pin_follow_a: assert property (
      @(posedge core_clk) disable iff (rst)
      pin_en_q |=> master_clock_out == $past(gif.master_q))
      else $error("pin does not follow the master clock");
   clean_switch_a: assert property (
      @(posedge core_clk) disable iff (rst)
      $changed(pin_en_q) |-> !$past(gif.master_q))
      else $error("pin gate switched during a high phase");
   stopped_pin_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !gif.running |=> ##1 !master_clock_out)
      else $error("pin toggles while the master clock is stopped");

endmodule : cgen_pin_gate

/* cgen_cpu_clock.sv */
// Purpose: cpu master clock generation from a source clock, mode straps
//          and the gated master clock pin
// Assumes: core_clk much faster than the source clock; pins asynchronous
// Notes:   master clock is a level on core_clk, phase locked to source rises in pll modes
`include "cgen_map.svh"

module cgen_cpu_clock
   import cgen_pkg::*;
#(
   parameter int PW = 16,
   parameter int LOCK_CYC = `CGEN_PLL_LOCK_CYC
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic source_clock_in,
   input wire logic mode_strap_lo,
   input wire logic mode_strap_hi,
   input wire logic reset_pin_n,
   input wire logic ext_source_present,
   input wire logic cpu_idle,
   input wire logic [15:0] io_addr,
   input wire logic [15:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   output logic [15:0] io_rdata,
   output logic master_clock_out,
   output logic master_clock,
   output logic cpu_step,
   output logic cpu_latch,
   output logic cpu_reset,
   output logic pll_enable,
   output logic osc_enable,
   output logic pll_locked,
   output logic [1:0] clock_mode
);

   // ****************************************
   // parameter checks
   // ****************************************
   if (PW < 4 || PW > 31) begin : g_pw_chk
      $error("PW out of range");
   end
   if (LOCK_CYC < 1 || LOCK_CYC > 4095) begin : g_lock_chk
      $error("LOCK_CYC out of range");
   end

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic src_prev_q;
   logic src_s;
   logic rstn_s;
   logic ext_s;
   logic [1:0] strap_s;
   logic src_rise;
   logic hw_rst;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
         src_prev_q <= 1'b0;
      end else begin
         sync1_q <= {ext_source_present, reset_pin_n, mode_strap_hi,
                     mode_strap_lo, source_clock_in};
         sync2_q <= sync1_q;
         src_prev_q <= sync2_q[0];
      end
   end

   always_comb begin
      src_s = sync2_q[0];
      strap_s = sync2_q[2:1];
      rstn_s = sync2_q[3];
      ext_s = sync2_q[4];
      src_rise = src_s && !src_prev_q;
      hw_rst = rst || !rstn_s;
   end

   // ****************************************
   // mode, lock and state
   // ****************************************
   cgen_mode_t mode_q;
   cgen_mode_t mode_d;
   cgen_state_t st_q;
   cgen_state_t st_d;
   logic [11:0] lock_q;
   logic [11:0] lock_d;
   logic locked;

   always_comb begin
      locked = (lock_q == 12'(LOCK_CYC));
      mode_d = mode_q;
      lock_d = lock_q;
      if (hw_rst) begin
         mode_d = cgen_mode_t'(strap_s);
      end
      if (hw_rst && mode_d != mode_q) begin
         lock_d = 12'h000;
      end else if (mode_q != CGEN_MODE_STRAP_HI && !locked && src_rise) begin
         lock_d = lock_q + 12'h001;
      end
      st_d = st_q;
      case (st_q)
         CGEN_HOLD: begin
            if (!hw_rst) begin
               st_d = (mode_q == CGEN_MODE_STRAP_HI || locked) ? CGEN_RUN : CGEN_LOCK;
            end
         end
         CGEN_LOCK: begin
            if (hw_rst) begin
               st_d = CGEN_HOLD;
            end else if (locked) begin
               st_d = CGEN_RUN;
            end
         end
         CGEN_RUN: begin
            if (hw_rst) begin
               st_d = CGEN_HOLD;
            end
         end
         default: begin
            st_d = CGEN_HOLD;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_q <= CGEN_MODE_STRAP_HI;
         lock_q <= 12'h000;
         st_q <= CGEN_HOLD;
      end else begin
         mode_q <= mode_d;
         lock_q <= lock_d;
         st_q <= st_d;
      end
   end

   // ****************************************
   // source period and master clock
   // ****************************************
   function automatic logic [PW-1:0] half_of(input logic [PW-1:0] per,
                                             input cgen_mode_t m);
      logic [PW-1:0] h;
      h = per;
      case (m)
         CGEN_MODE_STRAP_HI: h = per;
         CGEN_MUL1: h = per >> 1;
         CGEN_MUL2: h = per >> 2;
         CGEN_MUL4: h = per >> 3;
         default: h = per;
      endcase
      if (h == '0) begin
         h = {{(PW-1){1'b0}}, 1'b1};
      end
      return h;
   endfunction : half_of

   logic [PW-1:0] per_cnt_q;
   logic [PW-1:0] per_cnt_d;
   logic [PW-1:0] per_q;
   logic [PW-1:0] per_d;
   logic [PW-1:0] ph_q;
   logic [PW-1:0] ph_d;
   logic [PW-1:0] half;
   logic master_q;
   logic master_d;
   logic step_q;
   logic latch_q;
   logic run;

   always_comb begin
      run = (st_q == CGEN_RUN);
      half = half_of(per_q, mode_q);
      per_d = per_q;
      per_cnt_d = per_cnt_q;
      if (src_rise) begin
         per_d = per_cnt_q + {{(PW-1){1'b0}}, 1'b1};
         per_cnt_d = '0;
      end else if (per_cnt_q != '1) begin
         per_cnt_d = per_cnt_q + {{(PW-1){1'b0}}, 1'b1};
      end
      master_d = master_q;
      ph_d = ph_q;
      if (!run) begin
         master_d = 1'b0;
         ph_d = '0;
      end else if (mode_q != CGEN_MODE_STRAP_HI && src_rise) begin
         master_d = 1'b1;
         ph_d = '0;
      end else if (ph_q >= half - {{(PW-1){1'b0}}, 1'b1}) begin
         master_d = !master_q;
         ph_d = '0;
      end else begin
         ph_d = ph_q + {{(PW-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         per_cnt_q <= '0;
         per_q <= '0;
         ph_q <= '0;
         master_q <= 1'b0;
         step_q <= 1'b0;
         latch_q <= 1'b0;
      end else begin
         per_cnt_q <= per_cnt_d;
         per_q <= per_d;
         ph_q <= ph_d;
         master_q <= master_d;
         step_q <= master_d && !master_q;
         latch_q <= !master_d && master_q;
      end
   end

   // ****************************************
   // outputs and pin gate
   // ****************************************
   cgen_gate_if gif ();

   assign gif.master_q = master_q;
   assign gif.running = run;

   cgen_pin_gate u_gate (
      .core_clk(core_clk),
      .rst(rst),
      .io_addr(io_addr),
      .io_wdata(io_wdata),
      .io_wr(io_wr),
      .io_rd(io_rd),
      .io_rdata(io_rdata),
      .master_clock_out(master_clock_out),
      .gif(gif)
   );

   assign master_clock = master_q;
   assign cpu_step = step_q;
   assign cpu_latch = latch_q;
   assign cpu_reset = !run;
   assign pll_enable = (mode_q != CGEN_MODE_STRAP_HI);
   assign osc_enable = (mode_q == CGEN_MODE_STRAP_HI) && !ext_s;
   assign pll_locked = locked && (mode_q != CGEN_MODE_STRAP_HI);
   assign clock_mode = mode_q;

   // ****************************************
   // checks
   // ****************************************
   strap_take_a: assert property (
      @(posedge core_clk) disable iff (rst)
      hw_rst |=> mode_q == cgen_mode_t'($past(strap_s)))
      else $error("mode not taken from straps in reset");
   mode_hold_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !hw_rst |=> mode_q == $past(mode_q))
      else $error("mode changed while running");
   mode_strap_hi_nopll_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode_q == CGEN_MODE_STRAP_HI) |-> !pll_enable && !(osc_enable && ext_s))
      else $error("mode_strap_hi mode with pll or wrong oscillator");
   phase_lock_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (run && !hw_rst && mode_q != CGEN_MODE_STRAP_HI && src_rise) |=> master_q)
      else $error("master clock not locked to source edge");
   no_run_unlocked_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (mode_q != CGEN_MODE_STRAP_HI && !locked) |-> !run)
      else $error("pll mode running before lock");
   step_per_cycle_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (master_q && !$past(master_q)) |-> cpu_step ##1 !cpu_step)
      else $error("step not one pulse per master period");
   latch_low_a: assert property (
      @(posedge core_clk) disable iff (rst)
      cpu_latch |-> !master_q)
      else $error("latch strobe outside low phase");
   // master half period must not exceed 1000 core cycles for this check
   idle_toggle_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (cpu_idle && run && $changed(master_q))
      |-> ##[1:1000] ($changed(master_q) || !run))
      else $error("master clock stops in idle");

endmodule : cgen_cpu_clock

/* cgen_board_model.sv */
// Purpose: board model: source clock, hardware reset pin and mode straps
// Assumes: source clock is a fixed multiple of the core clock period
// Notes:   stray() moves the straps without reset, on purpose
module cgen_board_model #(
   parameter int SRC_HALF = 8,
   parameter int LOCK_CYC = 4
)(
   input wire logic core_clk,
   output logic source_clock_in,
   output logic mode_strap_lo,
   output logic mode_strap_hi,
   output logic reset_pin_n,
   output logic ext_source_present
);
   timeunit 1ns;
   timeprecision 100ps;

   int src_cnt;
   logic src_run;

   // ****************************************
   // source clock, started under reset
   // ****************************************
   initial begin
      source_clock_in = 1'b0;
      src_cnt = 0;
      src_run = 1'b0;
      reset_pin_n = 1'b0;
      {mode_strap_hi, mode_strap_lo} = 2'h0;
      ext_source_present = 1'b1;
   end

   always @(posedge core_clk) begin
      if (src_run) begin
         src_cnt <= (src_cnt == SRC_HALF - 1) ? 0 : src_cnt + 1;
         if (src_cnt == SRC_HALF - 1)
            source_clock_in <= #1 ~source_clock_in;
      end
   end

   // ****************************************
   // hardware reset with new straps
   // ****************************************
   task automatic restart(input logic [1:0] mode, input logic ext);
      @(posedge core_clk) #1;
      reset_pin_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      {mode_strap_hi, mode_strap_lo} = mode;
      ext_source_present = ext;
      src_run = 1'b1;
      // hold through lock plus four source cycles in pll modes, 8 core cycles in mode 0
      repeat ((mode == 2'h0) ? 8 : (LOCK_CYC + 4) * 2 * SRC_HALF)
         @(posedge core_clk);
      #1;
      reset_pin_n = 1'b1;
   endtask : restart

   task automatic stray(input logic [1:0] mode);
      @(posedge core_clk) #1;
      {mode_strap_hi, mode_strap_lo} = mode;
   endtask : stray
endmodule : cgen_board_model

/* testbench.sv */
// Purpose: self-checking bench of the cpu clock and pin gate block
// Assumes: source clock period of 16 core cycles, short lock count
// Notes:   io access through one-cycle read and write strobes
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int SRC_HALF = 8;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cpu_idle = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [15:0] io_wdata = 16'h0000;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic source_clock_in, mode_strap_lo, mode_strap_hi, reset_pin_n;
   logic ext_source_present, master_clock_out, master_clock, cpu_step;
   logic cpu_latch, cpu_reset, pll_enable, osc_enable, pll_locked;
   logic [15:0] io_rdata;
   logic [1:0] clock_mode;
   logic mon_on = 1'b0;
   int run_len = 0;
   int error_cnt = 0;
   int n_compared = 0;

   always #4 core_clk = ~core_clk;

   cgen_board_model #(.SRC_HALF(SRC_HALF), .LOCK_CYC(4)) u_board (
      .core_clk(core_clk), .source_clock_in(source_clock_in),
      .mode_strap_lo(mode_strap_lo), .mode_strap_hi(mode_strap_hi),
      .reset_pin_n(reset_pin_n), .ext_source_present(ext_source_present));

   cgen_cpu_clock #(.PW(16), .LOCK_CYC(4)) u_dut (
      .core_clk(core_clk), .rst(rst), .source_clock_in(source_clock_in),
      .mode_strap_lo(mode_strap_lo), .mode_strap_hi(mode_strap_hi),
      .reset_pin_n(reset_pin_n), .ext_source_present(ext_source_present),
      .cpu_idle(cpu_idle), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
      .master_clock_out(master_clock_out), .master_clock(master_clock),
      .cpu_step(cpu_step), .cpu_latch(cpu_latch), .cpu_reset(cpu_reset),
      .pll_enable(pll_enable), .osc_enable(osc_enable),
      .pll_locked(pll_locked), .clock_mode(clock_mode));

   // ****************************************
   // helpers
   // ****************************************
   task automatic print_verdict();
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic timeout(input string what);
      error_cnt++;
      $display("unexpected %s: expected done, seen timeout", what);
      print_verdict();
   endtask : timeout

   task automatic tick();
      @(posedge core_clk) #1;
   endtask : tick

   task automatic io_write(input logic [15:0] a, input logic [15:0] d);
      tick();
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      tick();
      io_wr = 1'b0;
   endtask : io_write

   task automatic io_read(input logic [15:0] a, output logic [15:0] d);
      tick();
      io_addr = a;
      io_rd = 1'b1;
      tick();
      io_rd = 1'b0;
      d = io_rdata;
   endtask : io_read

   task automatic wait_run();
      int k;
      k = 0;
      while (cpu_reset !== 1'b0 && k < 300) begin
         tick();
         k++;
      end
      if (k == 300) timeout("cpu reset release");
   endtask : wait_run

   task automatic measure(output int per, output int hi);
      int k;
      k = 0;
      while (cpu_step !== 1'b1 && k < 200) begin
         tick();
         k++;
      end
      if (k == 200) timeout("cycle start");
      check("master at cycle start", 16'(master_clock), 16'h0001);
      per = 0;
      hi = 0;
      do begin
         tick();
         per++;
         if (cpu_latch === 1'b1) hi = per;
      end while (cpu_step !== 1'b1 && per < 200);
   endtask : measure

   task automatic count_rises(input int n, output int r);
      logic prev;
      prev = master_clock_out;
      r = 0;
      repeat (n) begin
         tick();
         if (master_clock_out === 1'b1 && prev === 1'b0) r++;
         prev = master_clock_out;
      end
   endtask : count_rises

   // ****************************************
   // pin high time monitor
   // ****************************************
   always @(negedge core_clk) begin
      if (!mon_on) begin
         run_len = 0;
      end else if (master_clock_out === 1'b1) begin
         run_len++;
      end else if (run_len != 0) begin
         check("pin high time", 16'(run_len), 16'(SRC_HALF / 4));
         run_len = 0;
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int per, hi, r;
      logic [15:0] d;
      logic [1:0] m;
      repeat (5) @(posedge core_clk);
      #1;
      rst = 1'b0;
      io_read(16'hffe8, d);
      check("gate after reset", d, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         m = (i < 2) ? 2'h0 : 2'(i - 1);
         u_board.restart(m, i != 0);
         check("cpu held in reset", 16'(cpu_reset), 16'h0001);
         wait_run();
         check("clock mode", 16'(clock_mode), 16'(m));
         check("pll enable", 16'(pll_enable), 16'(m != 2'h0));
         check("osc enable", 16'(osc_enable), 16'(i == 0));
         check("pll locked", 16'(pll_locked), 16'(m != 2'h0));
         repeat (40) tick();
         measure(per, hi);
         check("period", 16'(per), 16'((4 * SRC_HALF) >> m));
         check("latch phase", 16'(hi), 16'((2 * SRC_HALF) >> m));
      end
      u_board.stray(2'h1);
      repeat (60) tick();
      measure(per, hi);
      check("mode after stray", 16'(clock_mode), 16'h0003);
      check("period after stray", 16'(per), 16'h0004);
      mon_on = 1'b1;
      for (int k = 0; k < 4; k++) begin
         repeat (k) tick();
         io_write(16'hffe8, 16'hffff);
         repeat (8) tick();
         count_rises(64, r);
         check("pin gated", 16'(r), 16'h0000);
         io_read(16'hffe8, d);
         check("gate readback", d, 16'h0001);
         cpu_idle = 1'b1;
         io_write(16'hffe8, 16'h0000);
         repeat (8) tick();
         count_rises(64, r);
         check("pin in idle", 16'(r), 16'h0010);
         cpu_idle = 1'b0;
      end
      io_write(16'hffe9, 16'h0001);
      io_read(16'hffe9, d);
      check("unmapped read", d, 16'h0000);
      io_read(16'hffe8, d);
      check("gate untouched", d, 16'h0000);
      io_write(16'hffe8, 16'h0001);
      mon_on = 1'b0;
      rst = 1'b1;
      repeat (3) tick();
      rst = 1'b0;
      io_read(16'hffe8, d);
      check("gate after rst", d, 16'h0000);
      u_board.restart(2'h3, 1'b1);
      wait_run();
      repeat (40) tick();
      count_rises(64, r);
      check("pin after rst", 16'(r), 16'h0010);
      print_verdict();
   end
endmodule : testbench
